// ==== verilog/lawd_pkg.sv ====
// Purpose: shared constants and types for the local address window decoder
// Assumes: 32-bit local address space, registers on a 32-bit Avalon-MM slave
// Notes: attribute layout and status offsets are fixed here for every file
package lawd_pkg;
   // address space and window counts
   localparam int ADDR_W = 32;
   localparam int NUM_WIN = 7;
   localparam int NUM_PROG = 6;
   localparam int NUM_LB = 4;
   localparam int WIN_IDX_W = 3;
   localparam int SRC_W = 2;
   // field widths and positions
   localparam int CFG_SPAN_BITS = 21;
   localparam int CFG_BASE_W = ADDR_W - CFG_SPAN_BITS;
   localparam int LOW_BITS = 12;
   localparam int PROG_BASE_W = ADDR_W - LOW_BITS;
   localparam int SIZE_W = 6;
   localparam int ATTR_EN_BIT = 31;
   // size code n means 2^(n+1) bytes: 11 is 4 Kbytes, 30 is 2 Gbytes
   localparam logic [SIZE_W-1:0] SIZE_MIN = 6'h0b;
   localparam logic [SIZE_W-1:0] SIZE_MAX = 6'h1e;
   // reset values
   localparam logic [ADDR_W-1:0] CFG_BASE_RST = 32'hff40_0000;
   localparam logic [PROG_BASE_W-1:0] PROG_BASE_RST = 20'h0_0000;
   localparam logic [SIZE_W-1:0] SIZE_RST = 6'h00;
   // register byte offsets
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] OFS_CFG_BASE = 8'h00;
   localparam logic [REG_AW-1:0] OFS_LB_WIN = 8'h20;
   localparam logic [REG_AW-1:0] OFS_DDR_WIN = 8'ha0;
   localparam logic [REG_AW-1:0] OFS_ATTR = 8'h04;
   localparam logic [REG_AW-1:0] WIN_STRIDE = 8'h08;
   localparam logic [REG_AW-1:0] OFS_MISS_ADDR = 8'hf0;
   localparam logic [REG_AW-1:0] OFS_STATUS = 8'hf4;
   localparam int NUM_DDR = NUM_PROG - NUM_LB;

   typedef enum logic [1:0] {TGT_NONE, TGT_CFG, TGT_LBC, TGT_DDR} lawd_tgt_e;
   typedef enum logic {BUS_IDLE, BUS_ACK} lawd_bus_e;

   // transaction offered by an initiator
   typedef struct packed {
      logic valid;
      logic write;
      logic [SRC_W-1:0] src;
      logic [ADDR_W-1:0] addr;
   } lawd_req_s;

   // transaction with its routing decision attached
   typedef struct packed {
      logic valid;
      logic write;
      logic [SRC_W-1:0] src;
      logic [ADDR_W-1:0] addr;
      lawd_tgt_e tgt;
      logic [WIN_IDX_W-1:0] win;
      logic miss;
   } lawd_route_s;

   // fixed target of each window number
   function automatic lawd_tgt_e win_target(input logic [WIN_IDX_W-1:0] w);
      lawd_tgt_e t;
      t = TGT_NONE;
      if (w == 3'h0) begin
         t = TGT_CFG;
      end else if (w <= 3'(NUM_LB)) begin
         t = TGT_LBC;
      end else if (w < 3'(NUM_WIN)) begin
         t = TGT_DDR;
      end
      return t;
   endfunction
endpackage

// ==== verilog/lawd_win_match.sv ====
// Purpose: address compare for one programmable window
// Assumes: size code n selects a 2^(n+1) byte window
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
module lawd_win_match
   import lawd_pkg::*;
#(
   parameter int AW = 32
) (
   input wire logic [AW-1:0] addr_i, // transaction address
   input wire logic [AW-LOW_BITS-1:0] base_i, // window base, high bits
   input wire logic en_i, // window enable
   input wire logic [SIZE_W-1:0] size_i, // size code
   output logic hit_o // address falls inside window
);
   logic [AW-LOW_BITS-1:0] cmp_mask;
   logic size_ok;

   // compare only the bits above the window size; a misaligned base drops its low bits
   always_comb begin
      for (int k = 0; k < AW - LOW_BITS; k++) begin
         cmp_mask[k] = ((k + LOW_BITS) > int'(size_i));
      end
   end

   // out-of-range size codes never hit, so a bad setting cannot claim space
   assign size_ok = (size_i >= SIZE_MIN) && (size_i <= SIZE_MAX);
   assign hit_o = en_i && size_ok && (((addr_i[AW-1:LOW_BITS] ^ base_i) & cmp_mask) == '0);
endmodule // lawd_win_match

// ==== verilog/lawd_prio_pick.sv ====
// Purpose: pick the lowest numbered hit among programmable windows
// Assumes: hit vector bit 0 is window 1
// Notes: overlapping programmable windows resolve to the lowest number
`timescale 1ns/1ps
module lawd_prio_pick
   import lawd_pkg::*;
#(
   parameter int N = 6
) (
   input wire logic [N-1:0] hit_i, // per-window hits
   output logic any_o, // some window hit
   output logic [WIN_IDX_W-1:0] win_o // window number of winner
);
   // scan downward so the lowest index is the last to be assigned
   always_comb begin
      any_o = 1'b0;
      win_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (hit_i[i]) begin
            any_o = 1'b1;
            win_o = WIN_IDX_W'(i + 1);
         end
      end
   end
endmodule // lawd_prio_pick

// ==== verilog/lawd_decoder.sv ====
// Purpose: route each local transaction to its target by address window
// Assumes: one common map for all initiators; registers on Avalon-MM
// Notes: one cycle from request to route; unmapped addresses come out as misses
`timescale 1ns/1ps
module lawd_decoder
   import lawd_pkg::*;
(
   input wire logic core_clk_i, // system bus clock
   input wire logic nrst_i, // asynchronous reset, active low
   input wire logic [REG_AW-1:0] avs_address_i, // register byte address
   input wire logic avs_read_i, // register read request
   input wire logic avs_write_i, // register write request
   input wire logic [31:0] avs_writedata_i, // register write data
   input wire logic [3:0] avs_byteenable_i, // write byte lanes
   output logic [31:0] avs_readdata_o, // register read data
   output logic avs_waitrequest_o, // high until the access is answered
   input wire lawd_pkg::lawd_req_s req_i, // transaction from any initiator
   output lawd_pkg::lawd_route_s route_o // routed transaction
);
   import lawd_pkg::*;

   // register state
   logic [CFG_BASE_W-1:0] cfg_base_reg;
   logic [PROG_BASE_W-1:0] win_base_reg [NUM_PROG];
   logic win_en_reg [NUM_PROG];
   logic [SIZE_W-1:0] win_size_reg [NUM_PROG];
   logic [ADDR_W-1:0] miss_addr_reg;
   logic miss_flag_reg;
   lawd_bus_e bus_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   lawd_route_s route_reg;
   lawd_route_s route_next;

   // decode results
   logic cfg_hit;
   logic [NUM_PROG-1:0] prog_hit;
   logic prog_any;
   logic [WIN_IDX_W-1:0] prog_win;
   logic acc_take;
   logic wr_take;
   logic [WIN_IDX_W-1:0] acc_win;
   logic acc_attr;
   logic [31:0] rd_val;
   logic [31:0] cfg_base_word;
   logic [31:0] cfg_wr;
   logic cfg_sel;
   logic clr_miss;
   logic [31:0] status_word;

   // map a register address to a programmable window number, 0 if none
   // windows 1-4 sit in the local bus block, 5-6 in the memory block; offsets between decode to nothing
   function automatic logic [WIN_IDX_W-1:0] reg_win(input logic [REG_AW-1:0] a);
      logic [WIN_IDX_W-1:0] w;
      logic [REG_AW-1:0] d;
      w = '0;
      d = '0;
      if (a >= OFS_LB_WIN && a < OFS_LB_WIN + WIN_STRIDE * REG_AW'(NUM_LB)) begin
         d = a - OFS_LB_WIN;
         w = WIN_IDX_W'(d[REG_AW-1:3]) + 3'h1;
      end else if (a >= OFS_DDR_WIN && a < OFS_DDR_WIN + WIN_STRIDE * REG_AW'(NUM_DDR)) begin
         d = a - OFS_DDR_WIN;
         w = WIN_IDX_W'(d[REG_AW-1:3]) + 3'(NUM_LB + 1);
      end
      return w;
   endfunction

   // apply byte enables to a stored word
   // untouched lanes keep their value; reserved bits are rebuilt as zero before the merge
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // configuration window: fixed 2-Mbyte span, no enable to clear
   // the region can be moved but never switched off, so the register space stays reachable
   assign cfg_hit = (req_i.addr[ADDR_W-1:CFG_SPAN_BITS] == cfg_base_reg);

   // one comparator per programmable window, all fed the same address
   // misaligned bases are tolerated: the bits under the window size simply do not compare
   generate
      for (genvar g = 0; g < NUM_PROG; g++) begin : g_win
         lawd_win_match #(
            .AW(ADDR_W)
         ) u_match (
            .addr_i(req_i.addr),
            .base_i(win_base_reg[g]),
            .en_i(win_en_reg[g]),
            .size_i(win_size_reg[g]),
            .hit_o(prog_hit[g])
         );
      end
   endgenerate

   lawd_prio_pick #(
      .N(NUM_PROG)
   ) u_pick (
      .hit_i(prog_hit),
      .any_o(prog_any),
      .win_o(prog_win)
   );

   // routing decision; initiator id does not enter the decode, so all share one map
   // the config compare sits ahead of the pick, so a relocated config region shadows any window under it
   always_comb begin
      route_next.valid = req_i.valid;
      route_next.write = req_i.write;
      route_next.src = req_i.src;
      route_next.addr = req_i.addr;
      route_next.tgt = TGT_NONE;
      route_next.win = '0;
      route_next.miss = 1'b0;
      if (req_i.valid) begin
         if (cfg_hit) begin
            route_next.win = '0;
            route_next.tgt = win_target(3'h0);
         end else if (prog_any) begin
            route_next.win = prog_win;
            route_next.tgt = win_target(prog_win);
         end else begin
            route_next.miss = 1'b1;
         end
      end
   end

   // route stage: registered so the output is a clean flop
   // one cycle of latency is traded for keeping the window compare off the target's input path
   // valid clears in reset so no target sees a phantom transfer
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         route_reg <= '0;
      end else begin
         route_reg <= route_next;
      end
   end

   assign route_o = route_reg;

   // write one to the status flag clears it; only lane 0 carries the flag
   assign clr_miss = wr_take && (avs_address_i == OFS_STATUS) && avs_byteenable_i[0] && avs_writedata_i[0];

   // last unmapped address and sticky miss flag; a new miss wins over the clear
   // the flag is sticky so a miss between two polls is not lost
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         miss_addr_reg <= '0;
         miss_flag_reg <= 1'b0;
      end else begin
         if (route_next.miss) begin
            miss_addr_reg <= req_i.addr;
            miss_flag_reg <= 1'b1;
         end else if (clr_miss) begin
            miss_flag_reg <= 1'b0;
         end
      end
   end

   // bus handshake: every access waits one cycle, then is answered for one cycle
   // the wait cycle lets the read mux land in a flop, so readdata leaves a register
   // a request still held in the ack cycle is not taken twice: idle returns only after it
   assign acc_take = (avs_read_i || avs_write_i) && (bus_reg == BUS_IDLE);
   assign wr_take = avs_write_i && (bus_reg == BUS_ACK);
   assign acc_win = reg_win(avs_address_i);
   assign acc_attr = (avs_address_i[2:0] == OFS_ATTR[2:0]);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_reg <= BUS_IDLE;
         wait_reg <= 1'b1;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (acc_take) begin
                  bus_reg <= BUS_ACK;
                  wait_reg <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_reg <= BUS_IDLE;
               wait_reg <= 1'b1;
            end
            default: begin
               bus_reg <= BUS_IDLE;
               wait_reg <= 1'b1;
            end
         endcase
      end
   end

   assign avs_waitrequest_o = wait_reg;

   // configuration base as a full word, reserved low bits zero
   assign cfg_base_word = {cfg_base_reg, {CFG_SPAN_BITS{1'b0}}};

   // status word: only the sticky miss flag is implemented
   assign status_word = {31'h0000_0000, miss_flag_reg};

   // read mux; unmapped offsets return zero
   // reads have no side effect, so the miss flag clears only by a write
   always_comb begin
      rd_val = '0;
      if (avs_address_i == OFS_CFG_BASE) begin
         rd_val = cfg_base_word;
      end else if (avs_address_i == OFS_MISS_ADDR) begin
         rd_val = miss_addr_reg;
      end else if (avs_address_i == OFS_STATUS) begin
         rd_val = status_word;
      end else if (acc_win != '0) begin
         if (acc_attr) begin
            rd_val[ATTR_EN_BIT] = win_en_reg[acc_win-1];
            rd_val[SIZE_W-1:0] = win_size_reg[acc_win-1];
         end else begin
            rd_val = {win_base_reg[acc_win-1], {LOW_BITS{1'b0}}};
         end
      end
   end

   // read data captured when the answer is launched, held through the ack cycle
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_reg <= '0;
      end else if (acc_take && avs_read_i) begin
         rdata_reg <= rd_val;
      end
   end

   assign avs_readdata_o = rdata_reg;

   // configuration base: relocatable; new map takes effect on the next transaction
   assign cfg_sel = wr_take && (avs_address_i == OFS_CFG_BASE);
   assign cfg_wr = be_merge(cfg_base_word, avs_writedata_i, avs_byteenable_i); // low 21 bits dropped below

   // only the upper 11 bits exist; ones written to the reserved part have no effect
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_base_reg <= CFG_BASE_RST[ADDR_W-1:CFG_SPAN_BITS];
      end else if (cfg_sel) begin
         cfg_base_reg <= cfg_wr[ADDR_W-1:CFG_SPAN_BITS];
      end
   end

   // programmable window registers, base and attribute per window
   // a write lands at the edge where waitrequest is seen low, so the next transaction already sees it
   // enable and size are written together, so a window never shows a half-programmed attribute
   generate
      for (genvar g = 0; g < NUM_PROG; g++) begin : g_regs
         logic sel_base;
         logic sel_attr;
         logic [31:0] base_word;
         logic [31:0] attr_word;
         logic [31:0] base_wr;
         logic [31:0] attr_wr;

         assign sel_base = wr_take && (acc_win == WIN_IDX_W'(g + 1)) && !acc_attr;
         assign sel_attr = wr_take && (acc_win == WIN_IDX_W'(g + 1)) && acc_attr;
         assign base_word = {win_base_reg[g], {LOW_BITS{1'b0}}};
         assign attr_word = {win_en_reg[g], {(31 - SIZE_W){1'b0}}, win_size_reg[g]};
         assign base_wr = be_merge(base_word, avs_writedata_i, avs_byteenable_i);
         assign attr_wr = be_merge(attr_word, avs_writedata_i, avs_byteenable_i);

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               win_base_reg[g] <= PROG_BASE_RST;
               win_en_reg[g] <= 1'b0;
               win_size_reg[g] <= SIZE_RST;
            end else begin
               if (sel_base) begin
                  win_base_reg[g] <= base_wr[ADDR_W-1:LOW_BITS];
               end
               if (sel_attr) begin
                  win_en_reg[g] <= attr_wr[ATTR_EN_BIT];
                  win_size_reg[g] <= attr_wr[SIZE_W-1:0];
               end
            end
         end
      end
   endgenerate
endmodule // lawd_decoder

// ==== sim/lawd_decoder_chk.sv ====
// Purpose: port checks for the window decoder
// Assumes: bound to every decoder instance
// Notes: config base is shadowed from bus writes
`timescale 1ns/1ps
module lawd_decoder_chk (
   input wire logic core_clk_i, // clock
   input wire logic nrst_i, // reset, low
   input wire logic [7:0] avs_address_i, // reg addr
   input wire logic avs_read_i, // read
   input wire logic avs_write_i, // write
   input wire logic [31:0] avs_writedata_i, // wdata
   input wire logic [3:0] avs_byteenable_i, // lanes
   input wire logic [31:0] avs_readdata_o, // rdata
   input wire logic avs_waitrequest_o, // wait
   input wire lawd_pkg::lawd_req_s req_i, // request
   input wire lawd_pkg::lawd_route_s route_o // decision
);
   import lawd_pkg::*;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [10:0] cfg_reg;
   logic [10:0] req_top;
   assign req_top = req_i.addr[31:21];
   // shadow of the config base, so priority is judged from the ports alone
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_reg <= CFG_BASE_RST[31:21];
      end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CFG_BASE) begin
         cfg_reg[10:3] <= avs_byteenable_i[3] ? avs_writedata_i[31:24] : cfg_reg[10:3];
         cfg_reg[2:0] <= avs_byteenable_i[2] ? avs_writedata_i[23:21] : cfg_reg[2:0];
      end
   end
   chk_route_lat: assert property (req_i.valid |=> route_o.valid)
      else $error("no route after request");
   chk_no_spur: assert property (!req_i.valid |=> !route_o.valid && !route_o.miss)
      else $error("route without request");
   chk_addr_same: assert property (req_i.valid |=> route_o.addr == $past(req_i.addr))
      else $error("address altered");
   chk_src_same: assert property (req_i.valid |=> route_o.src == $past(req_i.src) &&
      route_o.write == $past(req_i.write)) else $error("source or direction altered");
   chk_cfg_wins: assert property (req_i.valid && req_top == cfg_reg |=>
      route_o.tgt == TGT_CFG && route_o.win == 3'h0) else $error("config hit lost");
   chk_cfg_size: assert property (route_o.tgt == TGT_CFG |-> $past(req_top) == $past(cfg_reg))
      else $error("config target outside its region");
   chk_lb_win: assert property (route_o.tgt == TGT_LBC |-> route_o.win inside {[3'h1:3'h4]})
      else $error("local bus from wrong window");
   chk_ddr_win: assert property (route_o.tgt == TGT_DDR |-> route_o.win inside {3'h5, 3'h6})
      else $error("memory from wrong window");
   chk_miss_form: assert property (route_o.miss |-> route_o.valid && route_o.tgt == TGT_NONE &&
      route_o.win == 3'h0) else $error("bad miss encoding");
   chk_wait_ack: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |->
      ##[1:2] !avs_waitrequest_o) else $error("access not answered");
   chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("ack longer than one cycle");
   cover property (route_o.miss);
   cover property (route_o.tgt == TGT_CFG);
   cover property (avs_write_i && !avs_waitrequest_o);
endmodule // lawd_decoder_chk

bind lawd_decoder lawd_decoder_chk lawd_decoder_chk_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .req_i(req_i), .route_o(route_o));

// ==== sim/lawd_init_model.sv ====
// Purpose: initiator side, core or engine issuing transactions
// Assumes: one transaction per cycle at most
// Notes: idle address is scrambled so stale values never pass
`timescale 1ns/1ps
module lawd_init_model (
   input wire logic core_clk_i, // clock
   input wire logic nrst_i, // reset, low
   input wire logic go_i, // issue now
   input wire logic [31:0] addr_i, // address
   input wire logic [1:0] src_i, // initiator
   input wire logic wr_i, // write
   output lawd_pkg::lawd_req_s req_o // to decoder
);
   import lawd_pkg::*;
   // all initiators share one map, so only src tells them apart
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_o <= '0;
      end else if (go_i) begin
         req_o <= '{valid: 1'b1, write: wr_i, src: src_i, addr: addr_i};
      end else begin
         req_o.valid <= 1'b0;
         req_o.addr <= ~req_o.addr;
      end
   end
endmodule // lawd_init_model

// ==== sim/lawd_decoder_tb.sv ====
// Purpose: self-checking bench for the window decoder
// Assumes: reference map kept as register images
// Notes: every route is compared one cycle after its request
`timescale 1ns/1ps
module lawd_decoder_tb;
   import lawd_pkg::*;
   logic core_clk_i, nrst_i, rd, wr, wt, go, iw;
   logic [7:0] adr;
   logic [31:0] wd, rdat, ia, msk;
   logic [3:0] be;
   logic [1:0] isrc;
   lawd_req_s req;
   lawd_route_s rt, e;
   lawd_route_s q[$];
   logic [31:0] m [64];
   int bad_count, total_checks;
   lawd_init_model lawd_init_model_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .go_i(go), .addr_i(ia),
      .src_i(isrc), .wr_i(iw), .req_o(req));
   lawd_decoder lawd_decoder_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .req_i(req), .route_o(rt));
   // 250 MHz
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   function automatic int wo(input int w);
      return w <= 4 ? 8'h20 + 8 * (w - 1) : 8'ha0 + 8 * (w - 5);
   endfunction
   // only implemented bits stick; everything else reads 0
   function automatic logic [31:0] wmask(input int o);
      if (o == 0) return 32'hffe0_0000;
      if ((o >= 8'h20 && o < 8'h40) || (o >= 8'ha0 && o < 8'hb0)) return o[2] ? 32'h8000_003f : 32'hffff_f000;
      return 32'h0;
   endfunction
   assign msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask(adr);
   // reference decode: config first, then the lowest enabled window
   function automatic lawd_route_s ref_route(input lawd_req_s r);
      lawd_route_s x;
      int o, c;
      x = '{valid: 1'b1, write: r.write, src: r.src, addr: r.addr, tgt: TGT_NONE, win: 3'h0, miss: 1'b1};
      if (r.addr[31:21] == m[0][31:21]) begin
         x.tgt = TGT_CFG;
         x.miss = 1'b0;
         return x;
      end
      for (int w = 6; w >= 1; w--) begin
         o = wo(w) / 4;
         c = m[o + 1][5:0];
         if (m[o + 1][31] && c >= 11 && c <= 30 && (r.addr >> (c + 1)) == (m[o] >> (c + 1))) begin
            x.tgt = w <= 4 ? TGT_LBC : TGT_DDR;
            x.win = w[2:0];
            x.miss = 1'b0;
         end
      end
      return x;
   endfunction
   task automatic err(input string s);
      bad_count++;
      $display("Error %0t %s", $time, s);
   endtask
   task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) err("register read mismatch");
   endtask
   task automatic chk_route(input lawd_route_s x);
      total_checks++;
      if (rt !== x) err("route mismatch");
   endtask
   task automatic complete_run();
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // routes are checked before the new request is queued; the status clear lands before the queueing, other writes after both
   always @(posedge core_clk_i) begin
      if (nrst_i) begin
         if (rt.valid !== 1'b0 || q.size() > 0) begin
            e = '0;
            if (q.size() > 0) e = q.pop_front();
            chk_route(e);
         end
         if (wr && !wt && adr == OFS_STATUS && be[0] && wd[0]) m[OFS_STATUS[7:2]] = 32'h0;
         if (req.valid) begin
            q.push_back(ref_route(req));
            // a miss sets the flag after any clear in the same cycle, so the set wins
            if (q[$].miss) begin
               m[OFS_MISS_ADDR[7:2]] = req.addr;
               m[OFS_STATUS[7:2]] = 32'h1;
            end
         end
         if (wr && !wt) m[adr[7:2]] = (m[adr[7:2]] & ~msk) | (wd & msk);
      end
   end
   // request stays up until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wt !== 1'b0 && n < 40);
      if (wt !== 1'b0) begin
         err("bus timeout");
         complete_run();
      end
      if (!w) chk_val(rdat, m[a[7:2]]);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic tx(input logic [31:0] a);
      go <= 1'b1;
      ia <= a;
      isrc <= 2'($urandom);
      iw <= 1'($urandom);
      @(posedge core_clk_i);
   endtask
   task automatic setw(input int w, input logic [31:0] b, input logic [5:0] c, input logic en);
      bus(1'b1, 8'(wo(w)), b, 4'hf);
      bus(1'b1, 8'(wo(w) + 4), {en, 25'h0, c}, 4'hf);
   endtask
   task automatic rd_all();
      for (int o = 0; o < 8'hb0; o += 4) bus(1'b0, o[7:0], 32'h0, 4'h0);
   endtask
   // both edges of each window and of the config region, back to back
   task automatic probe();
      logic [31:0] b, s;
      for (int w = 0; w <= 6; w++) begin
         b = w == 0 ? {m[0][31:21], 21'h0} : m[wo(w) / 4];
         s = w == 0 ? 32'h20_0000 : 32'h1 << (m[wo(w) / 4 + 1][5:0] + 1);
         for (int k = 0; k < 4; k++) tx(b + (k[1] ? s : 32'h0) - k[0]);
      end
      go <= 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic rst_all();
      nrst_i <= 1'b0;
      foreach (m[i]) m[i] = 32'h0;
      m[0] = CFG_BASE_RST;
      repeat (10) @(posedge core_clk_i);
      nrst_i <= 1'b1;
   endtask
   initial begin
      bad_count = 0;
      total_checks = 0;
      {nrst_i, rd, wr, go, iw, isrc, be, adr, wd, ia} = '0;
      void'($urandom(32'he60e));
      rst_all();
      rd_all();
      setw(1, 32'h8000_0000, 6'h17, 1'b1);
      setw(2, 32'h8000_0000, 6'h0b, 1'b1);
      setw(3, 32'hc000_0000, 6'h1b, 1'b1);
      setw(4, 32'hff80_0000, 6'h16, 1'b1);
      setw(5, 32'h0000_0000, 6'h1e, 1'b1);
      setw(6, 32'hff40_0000, 6'h14, 1'b0);
      probe();
      setw(6, 32'hff40_0000, 6'h14, 1'b1);
      bus(1'b1, OFS_CFG_BASE, 32'h8000_0000, 4'h8);
      probe();
      rd_all();
      repeat (40) begin
         bus(1'b1, 8'($urandom % 60 * 4), $urandom, 4'($urandom));
         repeat (8) tx($urandom);
         probe();
         bus(1'b0, OFS_MISS_ADDR, 32'h0, 4'h0);
         bus(1'b0, OFS_STATUS, 32'h0, 4'h0);
         bus(1'b1, OFS_STATUS, 32'h1, 4'($urandom));
         bus(1'b0, OFS_STATUS, 32'h0, 4'h0);
      end
      rd_all();
      rst_all();
      rd_all();
      complete_run();
   end
endmodule // lawd_decoder_tb
